// ### logic/flash_ctrl_pkg.sv
package flash_ctrl_pkg;
  // ****************************************
  // widths and address fields
  // ****************************************
  localparam int ADDR_W    = 20;                 // byte address into the flash window
  localparam int FW_W      = 128;                // flash word
  localparam int BW_W      = 32;                 // bus word
  localparam int FWA_LSB   = 4;                  // 16 bytes per flash word
  localparam int FWA_W     = ADDR_W - FWA_LSB;
  localparam int WSEL_LSB  = 2;
  localparam int WSEL_MSB  = 3;
  localparam int WST_W     = 4;
  localparam int PAGE_LSB  = 9;                  // 4096-bit page = 512 bytes
  localparam int PAGE_W    = ADDR_W - PAGE_LSB;
  localparam int SECT_W    = 5;
  localparam int SECT_CNT  = 19;
  localparam int SMALL_LSB = 13;                 // 8 kB small sectors
  localparam int SMALL_MSB = 15;
  localparam int LARGE_LSB = 16;                 // 64 kB large sectors
  localparam int EE_ADDR_W = 14;                 // 16 kB eeprom
  localparam int EE_DATA_W = 8;
  // ****************************************
  // fixed values
  // ****************************************
  localparam logic [ADDR_W-1:0] LARGE_BASE      = 20'h10000;
  localparam logic [SECT_W-1:0] SMALL_FIRST_NUM = 5'h0B;
  localparam logic [SECT_W-1:0] LARGE_ONE       = 5'h01;
  localparam logic [FWA_W-1:0]  FWA_ONE         = 16'h0001;
  localparam logic [FWA_W-1:0]  FWA_ZERO        = 16'h0000;
  localparam logic [WST_W-1:0]  WST_INIT        = 4'hF;
  localparam logic [WST_W-1:0]  WST_ZERO        = 4'h0;
  localparam logic [WST_W-1:0]  WST_ONE         = 4'h1;
  localparam logic [1:0]        LATCH_LAST      = 2'h3;
  localparam logic [1:0]        LATCH_ONE       = 2'h1;
  localparam logic [1:0]        LATCH_ZERO      = 2'h0;
  localparam int IDX_LOCK_BIT   = 0;             // protection word layout
  localparam int IDX_SECURE_LSB = 1;
  localparam int IDX_PROG_BIT   = 20;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {OP_READ = 2'h0, OP_PROG = 2'h1, OP_ERASE = 2'h2} op_t;
  typedef enum {ST_INIT, ST_IDLE, ST_RD, ST_SPEC, ST_PROG, ST_ERASE, ST_EE} state_t;
endpackage

// ### logic/read_buf_line.sv
`timescale 1ns/10ps
module read_buf_line import flash_ctrl_pkg::*; (
  input  wire logic             clk_sys,  // controller clock
  input  wire logic             rst_n,    // async reset, low
  input  wire logic             inval,    // drop the line
  input  wire logic             load,     // capture tag and data
  input  wire logic [FWA_W-1:0] tag_in,   // flash word address
  input  wire logic [FW_W-1:0]  data_in,  // flash word
  output logic                  valid,    // line holds data
  output logic      [FWA_W-1:0] tag,      // stored address
  output logic      [FW_W-1:0]  data      // stored word
);
  // invalidate wins over a load in the same cycle
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      valid <= 1'b0;
      tag   <= FWA_ZERO;
      data  <= '0;
    end else if (inval) begin
      valid <= 1'b0;
    end else if (load) begin
      valid <= 1'b1;
      tag   <= tag_in;
      data  <= data_in;
    end
  end
endmodule

// ### logic/flash_index_waitstate_ctrl.sv
`timescale 1ns/10ps
module flash_index_waitstate_ctrl import flash_ctrl_pkg::*; (
  input  wire logic                 clk_sys,             // branch clock
  input  wire logic                 rst_n,               // async reset, low
  input  wire logic                 bus_req,             // request, held until bus_ready
  input  wire logic [1:0]           bus_op,              // read, program, erase
  input  wire logic                 bus_eeprom,          // target eeprom
  input  wire logic [ADDR_W-1:0]    bus_addr,            // byte address
  input  wire logic [BW_W-1:0]      bus_wdata,           // write data
  output logic                      bus_ready,           // one-cycle completion
  output logic                      bus_err,             // with bus_ready: refused
  output logic      [BW_W-1:0]      bus_rdata,           // read data
  input  wire logic                 index_sector_select, // map protection sector
  input  wire logic [WST_W-1:0]     read_wait_count,     // read wait-states
  input  wire logic                 buffer_enable,       // keep flash words in lines
  input  wire logic                 spec_enable,         // prefetch next word
  input  wire logic                 cfg_access,          // config register touched
  input  wire logic                 latch_read,          // data latch was read
  output logic                      fl_rd,               // flash read in progress
  output logic                      fl_prog,             // program pulse
  output logic                      fl_erase,            // erase pulse
  output logic                      fl_index,            // access hits protection sector
  output logic      [FWA_W-1:0]     fl_addr,             // flash word address
  output logic      [PAGE_W-1:0]    fl_page,             // page of program or erase
  output logic      [SECT_W-1:0]    fl_sector,           // sector of erase
  output logic      [FW_W-1:0]      fl_wdata,            // program word
  input  wire logic [FW_W-1:0]      fl_rdata,            // array read data
  input  wire logic                 fl_done,             // program or erase finished
  output logic                      ee_req,              // eeprom pulse
  output logic      [1:0]           ee_op,               // eeprom operation
  output logic      [EE_ADDR_W-1:0] ee_addr,             // eeprom byte address
  output logic      [EE_DATA_W-1:0] ee_wdata,            // eeprom byte
  input  wire logic [EE_DATA_W-1:0] ee_rdata,            // eeprom read byte
  input  wire logic                 ee_done,             // eeprom finished
  output logic                      debug_lock,          // debug port locked
  output logic      [SECT_CNT-1:0]  sector_secure,       // per-sector security
  output logic                      index_locked,        // protection sector programmed
  output logic                      ctrl_busy            // not idle
);
  // ****************************************
  // decode
  // ****************************************
  state_t             state_r;
  logic [WST_W-1:0]   wait_r;
  logic [1:0]         lat_cnt_r;
  logic [FWA_W-1:0]   lat_fwa_r;
  logic [1:0]         rd_wsel_r;
  logic               l0_valid, l1_valid;
  logic [FWA_W-1:0]   l0_tag, l1_tag;
  logic [FW_W-1:0]    l0_data, l1_data;
  logic [FWA_W-1:0]   fwa;
  logic [1:0]         wsel;
  logic               take, tk_ee, tk_rd, tk_pr, tk_er, hit0, hit1;
  logic               tk_hit0, tk_hit1, tk_miss, wait_zero;
  logic               rd_done, spec_done, init_done, er_refuse, lat_full, prog_bad;
  logic               spec_go_miss, spec_go_hit, l0_load, l1_load, buf_inval;

  function automatic logic [BW_W-1:0] word_of(input logic [FW_W-1:0] d, input logic [1:0] s);
    return d[s*BW_W +: BW_W];
  endfunction

  // sector number from byte address, small ones numbered after the large ones
  function automatic logic [SECT_W-1:0] sector_of(input logic [ADDR_W-1:0] a);
    if (a < LARGE_BASE) begin
      return SMALL_FIRST_NUM + {2'h0, a[SMALL_MSB:SMALL_LSB]};
    end else begin
      return {1'b0, a[ADDR_W-1:LARGE_LSB]} - LARGE_ONE;
    end
  endfunction

  // request classification; protection reads never hit a line
  assign fwa       = bus_addr[ADDR_W-1:FWA_LSB];
  assign wsel      = bus_addr[WSEL_MSB:WSEL_LSB];
  assign take      = (state_r == ST_IDLE) && bus_req && !bus_ready;
  assign tk_ee     = take && bus_eeprom;
  assign tk_rd     = take && !bus_eeprom && (bus_op == OP_READ);
  assign tk_pr     = take && !bus_eeprom && (bus_op == OP_PROG);
  assign tk_er     = take && !bus_eeprom && (bus_op == OP_ERASE);
  assign hit0      = buffer_enable && !index_sector_select && l0_valid && (l0_tag == fwa);
  assign hit1      = buffer_enable && !index_sector_select && l1_valid && (l1_tag == fwa);
  assign tk_hit0   = tk_rd && hit0;
  assign tk_hit1   = tk_rd && !hit0 && hit1;
  assign tk_miss   = tk_rd && !hit0 && !hit1;
  assign wait_zero = (wait_r == WST_ZERO);
  assign rd_done   = (state_r == ST_RD) && wait_zero;
  assign spec_done = (state_r == ST_SPEC) && wait_zero;
  assign init_done = (state_r == ST_INIT) && wait_zero;
  assign er_refuse = tk_er && index_sector_select && index_locked;
  assign lat_full  = (lat_cnt_r == LATCH_LAST);
  assign prog_bad  = tk_pr && (lat_cnt_r != LATCH_ZERO) && (fwa != lat_fwa_r);
  // prefetch of the following word; while it runs new requests wait
  assign spec_go_miss = rd_done && !fl_index && buffer_enable && spec_enable;
  assign spec_go_hit  = tk_hit1 && spec_enable;
  assign l0_load   = (rd_done && !fl_index && buffer_enable) || tk_hit1;
  assign l1_load   = spec_done;
  assign buf_inval = init_done || cfg_access || latch_read || (rd_done && fl_index);

  // ****************************************
  // buffer lines
  // ****************************************
  read_buf_line u_line0 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .inval   (buf_inval),
    .load    (l0_load),
    .tag_in  (tk_hit1 ? l1_tag : fl_addr),
    .data_in (tk_hit1 ? l1_data : fl_rdata),
    .valid   (l0_valid),
    .tag     (l0_tag),
    .data    (l0_data)
  );

  read_buf_line u_line1 (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .inval   (buf_inval),
    .load    (l1_load),
    .tag_in  (fl_addr),
    .data_in (fl_rdata),
    .valid   (l1_valid),
    .tag     (l1_tag),
    .data    (l1_data)
  );

  // ****************************************
  // sequencer and wait-state counter
  // ****************************************
  // everything runs on the single branch clock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_INIT;
      wait_r  <= WST_INIT;
    end else begin
      case (state_r)
        ST_INIT, ST_SPEC: begin
          if (wait_zero) begin
            state_r <= ST_IDLE;
          end else begin
            wait_r <= wait_r - WST_ONE;
          end
        end
        ST_IDLE: begin
          if (tk_ee) begin
            state_r <= ST_EE;
          end else if (tk_miss) begin
            state_r <= ST_RD;
            wait_r  <= read_wait_count;
          end else if (spec_go_hit) begin
            state_r <= ST_SPEC;
            wait_r  <= read_wait_count;
          end else if (tk_pr && lat_full && !prog_bad) begin
            state_r <= ST_PROG;
          end else if (tk_er && !er_refuse) begin
            state_r <= ST_ERASE;
          end
        end
        ST_RD: begin
          if (wait_zero) begin
            state_r <= spec_go_miss ? ST_SPEC : ST_IDLE;
            wait_r  <= read_wait_count;
          end else begin
            wait_r <= wait_r - WST_ONE;
          end
        end
        ST_PROG, ST_ERASE: begin
          if (fl_done) begin
            state_r <= ST_IDLE;
          end
        end
        ST_EE: begin
          if (ee_done) begin
            state_r <= ST_IDLE;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // bus answer
  // ****************************************
  // buffer hits answer with no wait; misses after the counted wait-states
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_ready <= 1'b0;
      bus_err   <= 1'b0;
      bus_rdata <= '0;
    end else begin
      bus_ready <= tk_hit0 || tk_hit1 || rd_done || (tk_pr && !lat_full) || prog_bad
                   || er_refuse || ((state_r == ST_PROG || state_r == ST_ERASE) && fl_done)
                   || ((state_r == ST_EE) && ee_done);
      bus_err   <= er_refuse || prog_bad;
      if (tk_hit0) begin
        bus_rdata <= word_of(l0_data, wsel);
      end else if (tk_hit1) begin
        bus_rdata <= word_of(l1_data, wsel);
      end else if (rd_done) begin
        bus_rdata <= word_of(fl_rdata, rd_wsel_r);
      end else if ((state_r == ST_EE) && ee_done) begin
        bus_rdata <= {{(BW_W-EE_DATA_W){1'b0}}, ee_rdata};
      end
    end
  end

  // ****************************************
  // flash array port
  // ****************************************
  // reset starts the protection sector read that init needs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fl_rd     <= 1'b1;
      fl_index  <= 1'b1;
      fl_addr   <= FWA_ZERO;
      fl_prog   <= 1'b0;
      fl_erase  <= 1'b0;
      fl_page   <= '0;
      fl_sector <= '0;
      rd_wsel_r <= 2'h0;
    end else begin
      fl_prog  <= 1'b0;
      fl_erase <= 1'b0;
      if (tk_miss) begin
        fl_rd     <= 1'b1;
        fl_addr   <= fwa;
        fl_index  <= index_sector_select;
        rd_wsel_r <= wsel;
      end else if (spec_go_hit) begin
        fl_rd    <= 1'b1;
        fl_addr  <= l1_tag + FWA_ONE;
        fl_index <= 1'b0;
      end else if (rd_done) begin
        fl_rd    <= spec_go_miss;
        fl_index <= 1'b0;
        if (spec_go_miss) begin
          fl_addr <= fl_addr + FWA_ONE;
        end
      end else if (spec_done || init_done) begin
        fl_rd    <= 1'b0;
        fl_index <= 1'b0;
      end else if ((tk_pr && lat_full && !prog_bad) || (tk_er && !er_refuse)) begin
        fl_prog   <= tk_pr;
        fl_erase  <= tk_er;
        fl_addr   <= fwa;
        fl_index  <= index_sector_select;
        fl_page   <= bus_addr[ADDR_W-1:PAGE_LSB];
        fl_sector <= sector_of(bus_addr);
      end
    end
  end

  // ****************************************
  // program word latch
  // ****************************************
  // four bus words fill one flash word; a word for another flash word is refused and empties the latch
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lat_cnt_r <= LATCH_ZERO;
      lat_fwa_r <= FWA_ZERO;
      fl_wdata  <= '0;
    end else if (prog_bad) begin
      lat_cnt_r <= LATCH_ZERO;
    end else if (tk_pr) begin
      lat_cnt_r <= lat_cnt_r + LATCH_ONE;
      lat_fwa_r <= fwa;
      fl_wdata[wsel*BW_W +: BW_W] <= bus_wdata;
    end
  end

  // ****************************************
  // eeprom port
  // ****************************************
  // byte wide path through this controller only
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ee_req   <= 1'b0;
      ee_op    <= 2'h0;
      ee_addr  <= '0;
      ee_wdata <= '0;
    end else begin
      ee_req <= tk_ee;
      if (tk_ee) begin
        ee_op    <= bus_op;
        ee_addr  <= bus_addr[EE_ADDR_W-1:0];
        ee_wdata <= bus_wdata[EE_DATA_W-1:0];
      end
    end
  end

  // ****************************************
  // protection status
  // ****************************************
  // programming the protection sector sets the lock when the program finishes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      debug_lock    <= 1'b1;
      sector_secure <= '1;
      index_locked  <= 1'b0;
      ctrl_busy     <= 1'b1;
    end else begin
      ctrl_busy <= (state_r != ST_IDLE);
      if (init_done) begin
        debug_lock    <= fl_rdata[IDX_LOCK_BIT];
        sector_secure <= fl_rdata[IDX_SECURE_LSB +: SECT_CNT];
        index_locked  <= fl_rdata[IDX_PROG_BIT];
      end else if ((state_r == ST_PROG) && fl_done && fl_index) begin
        index_locked  <= 1'b1;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence miss_wait2_s;
    !bus_ready [*3] ##1 bus_ready;
  endsequence

  chk_index_erase_refused: assert property (
    er_refuse |=> bus_ready && bus_err && !fl_erase)
    else $error("protection sector erase not refused");
  chk_wait_states_two: assert property (
    (tk_miss && read_wait_count == 4'h2) |=> miss_wait2_s)
    else $error("read answer not after programmed wait-states");
  chk_lines_dropped: assert property (
    (cfg_access || latch_read) |=> !l0_valid && !l1_valid)
    else $error("buffer lines survive invalidation");
  chk_index_overlay_read: assert property (
    (tk_rd && index_sector_select) |=> fl_rd && fl_index)
    else $error("index read not sent to protection sector");
  chk_prog_whole_word: assert property (
    fl_prog |-> $past(tk_pr) && $past(lat_cnt_r) == LATCH_LAST)
    else $error("program issued before four words");
  chk_init_lock_load: assert property (
    init_done |=> debug_lock == $past(fl_rdata[IDX_LOCK_BIT]))
    else $error("debug lock not taken from protection sector");
  chk_eeprom_path: assert property (tk_ee |=> ee_req && !fl_rd && !fl_prog && !fl_erase)
    else $error("eeprom access not routed through eeprom port");
  chk_spec_next_word: assert property (
    spec_go_miss |=> fl_rd && fl_addr == $past(fl_addr) + FWA_ONE)
    else $error("prefetch not of next flash word");
endmodule

// ### testbench/flash_array_model.sv
`timescale 1ns/10ps
// ********
// flash array and eeprom stand-in
// ********
module flash_array_model import flash_ctrl_pkg::*; (
  input  wire logic                 clk_sys,  // controller clock
  input  wire logic                 rst_n,    // async reset, low
  input  wire logic                 fl_rd,    // read in progress
  input  wire logic                 fl_prog,  // program pulse
  input  wire logic                 fl_erase, // erase pulse
  input  wire logic                 fl_index, // protection sector
  input  wire logic [FWA_W-1:0]     fl_addr,  // word address
  output logic      [FW_W-1:0]      fl_rdata, // array word
  output logic                      fl_done,  // operation finished
  input  wire logic                 ee_req,   // eeprom pulse
  input  wire logic [EE_ADDR_W-1:0] ee_addr,  // eeprom address
  output logic      [EE_DATA_W-1:0] ee_rdata, // eeprom byte
  output logic                      ee_done   // eeprom finished
);
  logic [3:0] fl_cnt_r;
  logic [3:0] ee_cnt_r;
  logic       slow_r;
  logic [7:0] ee_byte;
  // word n carries its address, a sector marker and n; garbage when idle
  always_comb begin
    for (int n = 0; n < 4; n++) begin
      fl_rdata[32*n +: 32] = {fl_addr, fl_index ? 14'h0296 : 14'h0000, 2'(n)};
      if (fl_rd !== 1'b1) fl_rdata[32*n +: 32] = ~fl_rdata[32*n +: 32];
    end
  end
  // flash completion delays alternate prompt and slow
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      fl_cnt_r <= 4'h0;
      ee_cnt_r <= 4'h0;
      slow_r   <= 1'b0;
    end else begin
      if (fl_prog || fl_erase) begin
        fl_cnt_r <= slow_r ? 4'h6 : 4'h1;
        slow_r   <= ~slow_r;
      end else if (fl_cnt_r != 4'h0) fl_cnt_r <= fl_cnt_r - 4'h1;
      if (ee_req) ee_cnt_r <= 4'h3;
      else if (ee_cnt_r != 4'h0) ee_cnt_r <= ee_cnt_r - 4'h1;
    end
  end
  // byte valid only with done, inverted otherwise
  assign ee_byte  = ee_addr[7:0] ^ 8'h3C;
  assign fl_done  = (fl_cnt_r == 4'h1);
  assign ee_done  = (ee_cnt_r == 4'h1);
  assign ee_rdata = ee_done ? ee_byte : ~ee_byte;
endmodule

// ### testbench/testbench.sv
`timescale 1ns/10ps
// ********
// bench top
// ********
module testbench import flash_ctrl_pkg::*; ;
  localparam logic [33:0] OK_E  = 34'h000000000;
  localparam logic [33:0] ERR_E = 34'h100000000;
  logic clk_sys, rst_n, bus_req, bus_eeprom, bus_ready, bus_err;
  logic [1:0] bus_op, ee_op;
  logic [ADDR_W-1:0] bus_addr, a;
  logic [BW_W-1:0] bus_wdata, bus_rdata, d;
  logic index_sector_select, buffer_enable, spec_enable, cfg_access, latch_read;
  logic [WST_W-1:0] read_wait_count, w;
  logic fl_rd, fl_prog, fl_erase, fl_index, fl_done, ee_req, ee_done;
  logic debug_lock, index_locked, ctrl_busy;
  logic [FWA_W-1:0] fl_addr;
  logic [PAGE_W-1:0] fl_page, pg_seen;
  logic [SECT_W-1:0] fl_sector, sec_seen;
  logic [FW_W-1:0] fl_wdata, fl_rdata, wd_seen, exp_w;
  logic [EE_ADDR_W-1:0] ee_addr;
  logic [EE_DATA_W-1:0] ee_wdata, ee_rdata;
  logic [SECT_CNT-1:0] sector_secure;
  logic [33:0] expq[$];
  logic [33:0] e_r;
  logic [23:0] ee_seen;
  int miscompares, n_compared, lat, n_erase, k0;
  integer seed;
  logic [ADDR_W-1:0] ea[4] = '{20'h02000, 20'h0E000, 20'h10000, 20'h5C000};
  logic [SECT_W-1:0] es[4] = '{5'h0C, 5'h12, 5'h00, 5'h04};

  flash_index_waitstate_ctrl u_dut (.clk_sys, .rst_n, .bus_req, .bus_op, .bus_eeprom,
    .bus_addr, .bus_wdata, .bus_ready, .bus_err, .bus_rdata, .index_sector_select,
    .read_wait_count, .buffer_enable, .spec_enable, .cfg_access, .latch_read, .fl_rd,
    .fl_prog, .fl_erase, .fl_index, .fl_addr, .fl_page, .fl_sector, .fl_wdata, .fl_rdata,
    .fl_done, .ee_req, .ee_op, .ee_addr, .ee_wdata, .ee_rdata, .ee_done, .debug_lock,
    .sector_secure, .index_locked, .ctrl_busy);
  flash_array_model u_far (.clk_sys, .rst_n, .fl_rd, .fl_prog, .fl_erase, .fl_index,
    .fl_addr, .fl_rdata, .fl_done, .ee_req, .ee_addr, .ee_rdata, .ee_done);

  // clock, 10 ns period
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic summarize();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  function automatic logic [33:0] rd(input logic [ADDR_W-1:0] x, input logic idx);
    return {2'b10, x[19:4], idx ? 14'h0296 : 14'h0000, x[3:2]};
  endfunction

  // one outstanding request, held until ready is sampled
  task automatic bus(input logic [1:0] op, input logic ee, input logic [ADDR_W-1:0] x,
                     input logic [BW_W-1:0] dw, input logic [33:0] e);
    lat = 0;
    expq.push_back(e);
    bus_req <= 1'b1;
    bus_op <= op;
    bus_eeprom <= ee;
    bus_addr <= x;
    bus_wdata <= dw;
    do begin
      @(posedge clk_sys);
      lat++;
    end while (bus_ready !== 1'b1 && lat < 500);
    if (lat >= 500) begin
      miscompares++;
      summarize();
    end
    bus_req <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic drop_lines(input logic sel);
    if (sel) latch_read <= 1'b1;
    else cfg_access <= 1'b1;
    @(posedge clk_sys);
    latch_read <= 1'b0;
    cfg_access <= 1'b0;
    @(posedge clk_sys);
  endtask

  // answer watcher and flash port snooper
  always @(posedge clk_sys) begin
    if (bus_ready === 1'b1 && expq.size() > 0) begin
      e_r = expq.pop_front();
      check("bus_err", bus_err, e_r[32]);
      if (e_r[33]) check("bus_rdata", bus_rdata, e_r[31:0]);
    end
    if (fl_prog === 1'b1) begin
      wd_seen = fl_wdata;
      pg_seen = fl_page;
    end
    if (fl_erase === 1'b1) begin
      sec_seen = fl_sector;
      n_erase++;
    end
    if (ee_req === 1'b1) ee_seen = {ee_op, ee_addr, ee_wdata};
  end

  // main sequence
  initial begin
    seed = 32'hE357;
    {bus_req, bus_eeprom, index_sector_select, spec_enable, cfg_access, latch_read} = '0;
    {bus_op, bus_addr, bus_wdata, rst_n} = '0;
    read_wait_count = 4'h2;
    buffer_enable = 1'b1;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    check("ctrl_busy", ctrl_busy, 1'b1);
    repeat (18) @(posedge clk_sys);
    check("ctrl_idle", ctrl_busy, 1'b0);
    check("debug_lock", debug_lock, 1'b0);
    check("sector_secure", sector_secure, 19'h0052C);
    check("index_locked", index_locked, 1'b0);
    for (int i = 0; i < 4; i++) begin
      w = 4'($random(seed)) & 4'h7;
      a = 20'($random(seed));
      read_wait_count <= w;
      drop_lines(i[0]);
      bus(OP_READ, 1'b0, a, '0, rd(a, 1'b0));
      check("miss_lat", lat, w + 3);
      bus(OP_READ, 1'b0, a ^ 20'h00004, '0, rd(a ^ 20'h00004, 1'b0));
      check("hit_lat", lat, 2);
      drop_lines(~i[0]);
      bus(OP_READ, 1'b0, a ^ 20'h00008, '0, rd(a ^ 20'h00008, 1'b0));
      check("inval_lat", lat, w + 3);
    end
    w = 4'h2;
    read_wait_count <= w;
    buffer_enable <= 1'b0;
    bus(OP_READ, 1'b0, 20'h00040, '0, rd(20'h00040, 1'b0));
    bus(OP_READ, 1'b0, 20'h00044, '0, rd(20'h00044, 1'b0));
    check("nobuf_lat", lat, w + 3);
    buffer_enable <= 1'b1;
    bus(OP_READ, 1'b0, 20'h00020, '0, rd(20'h00020, 1'b0));
    index_sector_select <= 1'b1;
    bus(OP_READ, 1'b0, 20'h00024, '0, rd(20'h00024, 1'b1));
    index_sector_select <= 1'b0;
    bus(OP_READ, 1'b0, 20'h00028, '0, rd(20'h00028, 1'b0));
    check("index_inval", lat, w + 3);
    a = 20'($random(seed)) & 20'hFFFF0;
    for (int k = 3; k >= 0; k--) begin
      d = $random(seed);
      exp_w[32*k +: 32] = d;
      bus(OP_PROG, 1'b0, a | 20'(k * 4), d, OK_E);
    end
    check("prog_word", wd_seen, exp_w);
    check("prog_page", pg_seen, a[19:9]);
    bus(OP_PROG, 1'b0, a, d, OK_E);
    bus(OP_PROG, 1'b0, a + 20'h00010, d, ERR_E);
    for (int k = 0; k < 4; k++) begin
      bus(OP_ERASE, 1'b0, ea[k], '0, OK_E);
      check("sector", sec_seen, es[k]);
    end
    index_sector_select <= 1'b1;
    for (int k = 0; k < 4; k++) bus(OP_PROG, 1'b0, 20'(k * 4), $random(seed), OK_E);
    check("locked", index_locked, 1'b1);
    k0 = n_erase;
    bus(OP_ERASE, 1'b0, 20'h00000, '0, ERR_E);
    check("no_erase", n_erase, k0);
    index_sector_select <= 1'b0;
    bus(OP_ERASE, 1'b0, 20'h04000, '0, OK_E);
    check("erase_ok", n_erase, k0 + 1);
    for (int k = 0; k < 3; k++) begin
      a = 20'($random(seed));
      d = $random(seed);
      bus(2'(k), 1'b1, a, d, k == 0 ? {26'h2000000, a[7:0] ^ 8'h3C} : OK_E);
      check("ee_port", ee_seen, {2'(k), a[13:0], d[7:0]});
    end
    spec_enable <= 1'b1;
    read_wait_count <= 4'h5;
    for (int k = 0; k < 6; k++) bus(OP_READ, 1'b0, 20'h30000 + 20'(k * 8), '0,
                                    rd(20'h30000 + 20'(k * 8), 1'b0));
    spec_enable <= 1'b0;
    repeat (10) @(posedge clk_sys);
    summarize();
  end
endmodule
